/* rtl/dvc_top.sv */
// dvc_top: per-channel digital volume control with soft stepping and pin volume
//
// Functional notes
// - independent gain per channel, +24 to -63.5 dB
// - left/right target from gain registers 65/66
// - mute and master gain from register 64
// - applied gain steps 0.125 dB per sample
// - step field can halve stepping rate
// - step field can disable ramping entirely
// - pin ignored unless register 116 bit 7
// - status bits 4/0 flag stepping finished
// - pin converter result overwrites gain setting
// - last pin converter code readable in 117
// - register 116 bit 6 picks converter clock
// - register 116 bits 2:0 set update rate
// - pin code to gain mapping, 127 mutes
`timescale 1ns/10ps
`default_nettype none
module dvc_top (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_sample_tick,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_vol_sense_cmp,
    output logic      [7:0] o_reg_rdata,
    output logic      [9:0] o_left_gain,
    output logic      [9:0] o_right_gain,
    output logic            o_left_mute,
    output logic            o_right_mute,
    output logic      [6:0] o_vol_sense_trial
);
    // ==========================================================
    // declarations
    localparam logic signed [9:0] APPLIED_MUTE = 10'sh200;

    logic [7:0]              soft_step_reg;
    logic [7:0]              mute_master_reg;
    logic [7:0]              left_gain_reg;
    logic [7:0]              right_gain_reg;
    logic [7:0]              pin_ctrl_reg;
    logic [6:0]              pin_read_reg;
    logic signed [9:0]       left_appl_reg;
    logic signed [9:0]       right_appl_reg;
    logic signed [9:0]       left_tgt;
    logic signed [9:0]       right_tgt;
    logic                    half_reg;
    logic                    step_now;
    logic                    step_off;
    logic                    pin_on;
    logic [7:0]              pin_gain;
    logic [7:0]              sar_div_reg;
    logic [13:0]             ivl_reg;
    logic                    sar_tick;
    logic                    sar_start;
    logic                    sar_done;
    logic [6:0]              sar_code;
    logic                    settled_l;
    logic                    settled_r;
    logic [1:0]              mast;
    dvc_pkg::dvc_step_e      step_mode;
    logic                    sar_tick_on;
    logic                    pin_write;
    logic                    left_wr;
    logic                    right_wr;
    logic [7:0]              settled_word;

    // ==========================================================
    // helpers
    function automatic logic [7:0] pin_to_gain(input logic [6:0] code);
        logic signed [8:0] g;
        g = 9'sh000;
        if (code == dvc_pkg::PIN_CODE_MUTE) begin
            g = 9'(dvc_pkg::GAIN_MUTE_HALF);
        end else if (code <= dvc_pkg::PIN_CODE_LAST_HALF) begin
            g = dvc_pkg::PIN_HALF_BASE - $signed({2'b00, code});
        end else begin
            g = dvc_pkg::PIN_WHOLE_BASE - $signed({1'b0, code, 1'b0});
        end
        return g[7:0];
    endfunction

    function automatic logic signed [9:0] to_applied(input logic [7:0] half, input logic mute);
        logic signed [7:0] h;
        h = $signed(half);
        if (mute || h == dvc_pkg::GAIN_MUTE_HALF) begin
            return APPLIED_MUTE;
        end
        if (h > dvc_pkg::GAIN_MAX_HALF) begin
            h = dvc_pkg::GAIN_MAX_HALF;
        end
        return {h, 2'b00};
    endfunction

    function automatic logic signed [9:0] step_toward(input logic signed [9:0] cur,
                                                      input logic signed [9:0] tgt,
                                                      input logic go,
                                                      input logic off);
        if (off) begin
            return tgt;
        end
        if (!go || cur == tgt) begin
            return cur;
        end
        return (cur < tgt) ? cur + 10'sh001 : cur - 10'sh001;
    endfunction

    // ==========================================================
    // target selection with mute and master modes
    assign mast = mute_master_reg[1:0];

    always_comb begin
        left_tgt  = to_applied(left_gain_reg, mute_master_reg[dvc_pkg::BIT_MUTE_LEFT]);
        right_tgt = to_applied(right_gain_reg, mute_master_reg[dvc_pkg::BIT_MUTE_RIGHT]);
        case (mast)
            dvc_pkg::DVC_MAST_L_FROM_R: left_tgt = to_applied(right_gain_reg,
                mute_master_reg[dvc_pkg::BIT_MUTE_LEFT]);
            dvc_pkg::DVC_MAST_R_FROM_L: right_tgt = to_applied(left_gain_reg,
                mute_master_reg[dvc_pkg::BIT_MUTE_RIGHT]);
            default: begin
            end
        endcase
    end

    // ==========================================================
    // step pacing
    assign step_mode = dvc_pkg::dvc_step_e'(soft_step_reg[1:0]);
    assign step_off  = (step_mode == dvc_pkg::DVC_STEP_OFF)
                    || (step_mode == dvc_pkg::DVC_STEP_OFF_RS);
    assign step_now  = i_sample_tick
                    && ((step_mode != dvc_pkg::DVC_STEP_HALF) || half_reg);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            half_reg <= 1'b0;
        end else if (i_sample_tick) begin
            half_reg <= ~half_reg;
        end
    end

    // ==========================================================
    // applied gain ramps
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            left_appl_reg  <= 10'sh000;
            right_appl_reg <= 10'sh000;
        end else begin
            left_appl_reg  <= step_toward(left_appl_reg, left_tgt, step_now, step_off);
            right_appl_reg <= step_toward(right_appl_reg, right_tgt, step_now, step_off);
        end
    end

    assign settled_l = (left_appl_reg == left_tgt);
    assign settled_r = (right_appl_reg == right_tgt);

    // ==========================================================
    // completion flags into the status word
    always_comb begin
        settled_word                         = 8'h00;
        settled_word[dvc_pkg::BIT_SETTLED_L] = settled_l;
        settled_word[dvc_pkg::BIT_SETTLED_R] = settled_r;
    end

    // ==========================================================
    // volume pin converter pacing
    assign pin_on = pin_ctrl_reg[dvc_pkg::BIT_PIN_ENABLE];

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sar_div_reg <= 8'h00;
        end else if (sar_div_reg == 8'(dvc_pkg::SAR_INT_TICK_CYC - 1)) begin
            sar_div_reg <= 8'h00;
        end else begin
            sar_div_reg <= sar_div_reg + 8'h01;
        end
    end

    assign sar_tick = pin_ctrl_reg[dvc_pkg::BIT_PIN_CLKSEL] ? i_sample_tick
                    : (sar_div_reg == 8'h00);

    // converter frozen while pin mode is off
    assign sar_tick_on = sar_tick && pin_on;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ivl_reg   <= 14'h0000;
            sar_start <= 1'b0;
        end else begin
            sar_start <= 1'b0;
            if (!pin_on) begin
                ivl_reg <= 14'h0000;
            end else if (sar_tick) begin
                if (ivl_reg == 14'h0000) begin
                    ivl_reg   <= 14'((dvc_pkg::SAR_RATE_BASE << pin_ctrl_reg[2:0]) - 1);
                    sar_start <= 1'b1;
                end else begin
                    ivl_reg <= ivl_reg - 14'h0001;
                end
            end
        end
    end

    dvc_sar u_sar (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_tick  (sar_tick_on),
        .i_start (sar_start),
        .i_cmp   (i_vol_sense_cmp),
        .o_trial (o_vol_sense_trial),
        .o_code  (sar_code),
        .o_done  (sar_done)
    );

    assign pin_gain = pin_to_gain(sar_code);
    assign pin_write = pin_on && sar_done;
    assign left_wr   = i_reg_wr && (i_reg_addr == dvc_pkg::ADDR_LEFT_GAIN);
    assign right_wr  = i_reg_wr && (i_reg_addr == dvc_pkg::ADDR_RIGHT_GAIN);

    // ==========================================================
    // control register writes: step, mute/master and pin control
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            soft_step_reg   <= dvc_pkg::RST_SOFT_STEP;
            mute_master_reg <= dvc_pkg::RST_MUTE_MAST;
            pin_ctrl_reg    <= dvc_pkg::RST_PIN_CTRL;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                dvc_pkg::ADDR_SOFT_STEP: soft_step_reg   <= {6'h00, i_reg_wdata[1:0]};
                dvc_pkg::ADDR_MUTE_MAST: mute_master_reg <= {4'h0, i_reg_wdata[3:0]};
                dvc_pkg::ADDR_PIN_CTRL:  pin_ctrl_reg    <= i_reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // gain registers, pin result wins over a host write
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            left_gain_reg  <= dvc_pkg::RST_GAIN;
            right_gain_reg <= dvc_pkg::RST_GAIN;
            pin_read_reg   <= 7'h00;
        end else if (pin_write) begin
            left_gain_reg  <= pin_gain;
            right_gain_reg <= pin_gain;
            pin_read_reg   <= sar_code;
        end else begin
            if (left_wr) begin
                left_gain_reg <= i_reg_wdata;
            end
            if (right_wr) begin
                right_gain_reg <= i_reg_wdata;
            end
        end
    end

    // ==========================================================
    // register reads
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                dvc_pkg::ADDR_SOFT_STEP:  o_reg_rdata <= soft_step_reg;
                dvc_pkg::ADDR_MUTE_MAST:  o_reg_rdata <= mute_master_reg;
                dvc_pkg::ADDR_LEFT_GAIN:  o_reg_rdata <= left_gain_reg;
                dvc_pkg::ADDR_RIGHT_GAIN: o_reg_rdata <= right_gain_reg;
                dvc_pkg::ADDR_PIN_CTRL:   o_reg_rdata <= pin_ctrl_reg;
                dvc_pkg::ADDR_PIN_READ:   o_reg_rdata <= {1'b0, pin_read_reg};
                dvc_pkg::ADDR_SETTLED:    o_reg_rdata <= settled_word;
                default:                  o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // gain outputs
    // left channel
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_left_gain <= 10'h000;
            o_left_mute <= 1'b0;
        end else begin
            o_left_gain <= left_appl_reg;
            o_left_mute <= (left_appl_reg == APPLIED_MUTE);
        end
    end

    // right channel
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_right_gain <= 10'h000;
            o_right_mute <= 1'b0;
        end else begin
            o_right_gain <= right_appl_reg;
            o_right_mute <= (right_appl_reg == APPLIED_MUTE);
        end
    end
endmodule // dvc_top
`default_nettype wire

/* rtl/dvc_pkg.sv */
// dvc_pkg: constants shared by the digital volume control block
package dvc_pkg;
    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_SOFT_STEP  = 8'h3F;
    localparam logic [7:0] ADDR_MUTE_MAST  = 8'h40;
    localparam logic [7:0] ADDR_LEFT_GAIN  = 8'h41;
    localparam logic [7:0] ADDR_RIGHT_GAIN = 8'h42;
    localparam logic [7:0] ADDR_PIN_CTRL   = 8'h74;
    localparam logic [7:0] ADDR_PIN_READ   = 8'h75;
    localparam logic [7:0] ADDR_SETTLED    = 8'h26;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_SOFT_STEP = 8'h00;
    localparam logic [7:0] RST_MUTE_MAST = 8'h00;
    localparam logic [7:0] RST_GAIN      = 8'h00;
    localparam logic [7:0] RST_PIN_CTRL  = 8'h00;

    // ==========================================================
    // field positions
    localparam int BIT_MUTE_LEFT   = 3;
    localparam int BIT_MUTE_RIGHT  = 2;
    localparam int BIT_PIN_ENABLE  = 7;
    localparam int BIT_PIN_CLKSEL  = 6;
    localparam int BIT_SETTLED_L   = 4;
    localparam int BIT_SETTLED_R   = 0;

    // ==========================================================
    // soft-step rates and master gain modes
    typedef enum logic [1:0] {
        DVC_STEP_EVERY  = 2'b00,
        DVC_STEP_HALF   = 2'b01,
        DVC_STEP_OFF    = 2'b10,
        DVC_STEP_OFF_RS = 2'b11
    } dvc_step_e;

    typedef enum logic [1:0] {
        DVC_MAST_INDEP  = 2'b00,
        DVC_MAST_L_FROM_R = 2'b01,
        DVC_MAST_R_FROM_L = 2'b10,
        DVC_MAST_RSV    = 2'b11
    } dvc_mast_e;

    // ==========================================================
    // gain encoding, half-dB codes and eighth-dB applied units
    localparam logic signed [7:0] GAIN_MAX_HALF = 8'sh30;
    localparam logic signed [7:0] GAIN_MIN_HALF = 8'sh81;
    localparam logic signed [7:0] GAIN_MUTE_HALF = 8'sh80;
    localparam int APPLIED_W = 10;
    localparam logic [6:0] PIN_CODE_LAST_HALF = 7'h5A;
    localparam logic [6:0] PIN_CODE_MUTE      = 7'h7F;
    localparam logic signed [8:0] PIN_HALF_BASE   = 9'sh024;
    localparam logic signed [8:0] PIN_WHOLE_BASE  = 9'sh07E;
    localparam int SAR_BITS = 7;

    // ==========================================================
    // volume pin converter timing
    localparam int CLK_PERIOD_NS  = 8;
    localparam int SAR_INT_TICK_NS = 1000;
    localparam int SAR_INT_TICK_CYC = (SAR_INT_TICK_NS / CLK_PERIOD_NS < 1) ? 1 :
                                      SAR_INT_TICK_NS / CLK_PERIOD_NS;
    localparam int SAR_RATE_BASE  = 64;
    localparam int SAR_TICK_CNT_W = 8;
    localparam int SAR_IVL_CNT_W  = 14;
endpackage : dvc_pkg

/* rtl/dvc_sar.sv */
// dvc_sar: 7-bit successive-approximation sequencer for the volume pin
`timescale 1ns/10ps
`default_nettype none
module dvc_sar (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_tick,
    input  wire logic       i_start,
    input  wire logic       i_cmp,
    output logic      [6:0] o_trial,
    output logic      [6:0] o_code,
    output logic            o_done
);
    // ==========================================================
    // state
    typedef enum logic [0:0] {
        DVC_SAR_IDLE = 1'b0,
        DVC_SAR_CONV = 1'b1
    } dvc_sar_e;

    dvc_sar_e   state_reg;
    logic [2:0] bit_reg;
    logic [6:0] mask;

    assign mask = 7'h01 << bit_reg;

    // ==========================================================
    // conversion sequence, msb first, one bit per converter tick
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= DVC_SAR_IDLE;
            bit_reg   <= 3'h0;
            o_trial   <= 7'h00;
            o_code    <= 7'h00;
            o_done    <= 1'b0;
        end else begin
            o_done <= 1'b0;
            case (state_reg)
                DVC_SAR_IDLE: begin
                    if (i_start) begin
                        state_reg <= DVC_SAR_CONV;
                        bit_reg   <= 3'(dvc_pkg::SAR_BITS - 1);
                        o_trial   <= 7'h40;
                    end
                end
                DVC_SAR_CONV: begin
                    if (i_tick) begin
                        if (bit_reg == 3'h0) begin
                            state_reg <= DVC_SAR_IDLE;
                            o_code    <= i_cmp ? o_trial : (o_trial & ~mask);
                            o_done    <= 1'b1;
                        end else begin
                            bit_reg <= bit_reg - 3'h1;
                            o_trial <= (i_cmp ? o_trial : (o_trial & ~mask)) | (mask >> 1);
                        end
                    end
                end
                default: state_reg <= DVC_SAR_IDLE;
            endcase
        end
    end
endmodule // dvc_sar
`default_nettype wire

/* verification/dvc_checker.sv */
// dvc_checker: port-level checks for the volume control block
`timescale 1ns/10ps
`default_nettype none
module dvc_checker (
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    input wire logic       i_sample_tick,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic       i_vol_sense_cmp,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [9:0] o_left_gain,
    input wire logic [9:0] o_right_gain,
    input wire logic       o_left_mute,
    input wire logic       o_right_mute,
    input wire logic [6:0] o_vol_sense_trial
);
    // ==========================================================
    // register shadows
    logic [1:0] step_reg;
    logic [3:0] ctl_reg;
    logic [7:0] lw_reg;
    logic       pin_reg;
    logic [1:0] idle_reg;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            step_reg <= 2'h0;
            ctl_reg  <= 4'h0;
            lw_reg   <= 8'h00;
            pin_reg  <= 1'b0;
        end else if (i_reg_wr) begin
            if (i_reg_addr == dvc_pkg::ADDR_SOFT_STEP) step_reg <= i_reg_wdata[1:0];
            if (i_reg_addr == dvc_pkg::ADDR_MUTE_MAST) ctl_reg <= i_reg_wdata[3:0];
            if (i_reg_addr == dvc_pkg::ADDR_LEFT_GAIN) lw_reg <= i_reg_wdata;
            if (i_reg_addr == dvc_pkg::ADDR_PIN_CTRL) pin_reg <= i_reg_wdata[7];
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) idle_reg <= 2'h0;
        else if (pin_reg) idle_reg <= 2'h0;
        else if (idle_reg != 2'h3) idle_reg <= idle_reg + 2'h1;
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence left_write_s;
        i_reg_wr && i_reg_addr == dvc_pkg::ADDR_LEFT_GAIN && step_reg[1] && !pin_reg
        && ctl_reg == 4'h0 && $signed(i_reg_wdata) <= 8'sh30;
    endsequence
    sequence left_applied_s;
        ##[1:4] o_left_gain == {lw_reg, 2'b00};
    endsequence
    gain_range_a: assert property ($signed(o_left_gain) <= 10'sd192
        && $signed(o_right_gain) <= 10'sd192) else $error("gain above top");
    ramp_step_a: assert property (!step_reg[1] && !$past(step_reg[1]) |->
        o_left_gain == $past(o_left_gain) || o_left_gain == $past(o_left_gain) + 10'h001
        || o_left_gain == $past(o_left_gain) - 10'h001) else $error("left step too large");
    ramp_tick_a: assert property (!step_reg[1] && $changed(o_right_gain)
        |-> $past(i_sample_tick, 2)) else $error("right step without tick");
    left_mute_a: assert property (o_left_mute == (o_left_gain == 10'h200))
        else $error("left mute flag wrong");
    right_mute_a: assert property (o_right_mute == (o_right_gain == 10'h200))
        else $error("right mute flag wrong");
    settled_rsv_a: assert property (i_reg_rd && i_reg_addr == dvc_pkg::ADDR_SETTLED
        |=> (o_reg_rdata & 8'hEE) == 8'h00) else $error("status spare bits set");
    step_read_a: assert property (i_reg_rd && i_reg_addr == dvc_pkg::ADDR_SOFT_STEP
        |=> o_reg_rdata == {6'h00, step_reg}) else $error("step field readback");
    ctl_read_a: assert property (i_reg_rd && i_reg_addr == dvc_pkg::ADDR_MUTE_MAST
        |=> o_reg_rdata == {4'h0, ctl_reg}) else $error("mute field readback");
    pin_idle_a: assert property (idle_reg == 2'h3 |-> $stable(o_vol_sense_trial))
        else $error("trial moves with pin off");
    no_ramp_a: assert property (left_write_s |=> left_applied_s)
        else $error("gain not applied at once");
endmodule // dvc_checker
bind dvc_top dvc_checker i_chk (.i_clk, .i_rst_n, .i_sample_tick, .i_reg_wr, .i_reg_rd,
    .i_reg_addr, .i_reg_wdata, .i_vol_sense_cmp, .o_reg_rdata, .o_left_gain, .o_right_gain,
    .o_left_mute, .o_right_mute, .o_vol_sense_trial);
`default_nettype wire

/* verification/dvc_vol_pin_model.sv */
// dvc_vol_pin_model: volume sense pin comparator seen by the converter
`timescale 1ns/10ps
`default_nettype none
module dvc_vol_pin_model (
    input  wire logic [6:0] i_trial,
    input  wire logic [6:0] i_level,
    output logic            o_cmp
);
    assign o_cmp = (i_level >= i_trial);
endmodule // dvc_vol_pin_model
`default_nettype wire

/* verification/tb_dvc_top.sv */
// tb_dvc_top: self-checking bench for the volume control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_dvc_top;
    logic       clk   = 1'b0;
    logic       rst_n = 1'b0;
    logic       tick  = 1'b0;
    logic       wr    = 1'b0;
    logic       rd    = 1'b0;
    logic [7:0] addr  = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [6:0] level = 7'h00;
    logic       cmp;
    logic [7:0] rdata;
    logic [9:0] lgain;
    logic [9:0] rgain;
    logic       lmute;
    logic       rmute;
    logic [6:0] trial;
    logic [7:0] rv;
    int         error_cnt   = 0;
    int         check_count = 0;
    int         cycles      = 0;
    localparam logic [7:0] RA [0:7] = '{8'h3F, 8'h40, 8'h41, 8'h42, 8'h74, 8'h75, 8'h26, 8'h10};
    localparam logic [7:0] RV [0:7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h00};
    always #4 clk = ~clk;
    dvc_top i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_sample_tick(tick), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_vol_sense_cmp(cmp),
        .o_reg_rdata(rdata), .o_left_gain(lgain), .o_right_gain(rgain), .o_left_mute(lmute),
        .o_right_mute(rmute), .o_vol_sense_trial(trial));
    dvc_vol_pin_model i_pin (.i_trial(trial), .i_level(level), .o_cmp(cmp));
    // ==========================================================
    // bus and tick helpers
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 9000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 wr = 1'b1;
        addr  = a;
        wdata = d;
        @(posedge clk);
        #1 wr = 1'b0;
    endtask
    task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1 rd = 1'b1;
        addr = a;
        @(posedge clk);
        #1 rd = 1'b0;
        settle(1);
        rv = rdata;
        `CHK(rv, exp)
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            #1 tick = 1'b1;
            @(posedge clk);
            #1 tick = 1'b0;
        end
        settle(3);
    endtask
    // ==========================================================
    // scenarios
    task automatic s_reset;
        for (int k = 0; k < 8; k++) check_reg(RA[k], RV[k]);
    endtask
    task automatic s_ramp;
        reg_wr(dvc_pkg::ADDR_LEFT_GAIN, 8'h01);
        check_reg(dvc_pkg::ADDR_SETTLED, 8'h01);
        ticks(2);
        `CHK(lgain, 10'h002)
        reg_wr(dvc_pkg::ADDR_LEFT_GAIN, 8'hFF);
        check_reg(dvc_pkg::ADDR_SETTLED, 8'h01);
        ticks(1);
        `CHK(lgain, 10'h001)
        ticks(5);
        `CHK(lgain, 10'h3FC)
        `CHK(rgain, 10'h000)
        check_reg(dvc_pkg::ADDR_SETTLED, 8'h11);
    endtask
    task automatic s_half;
        reg_wr(dvc_pkg::ADDR_SOFT_STEP, 8'h01);
        reg_wr(dvc_pkg::ADDR_RIGHT_GAIN, 8'h01);
        ticks(4);
        `CHK(rgain, 10'h002)
    endtask
    task automatic s_off;
        reg_wr(dvc_pkg::ADDR_SOFT_STEP, 8'hFE);
        check_reg(dvc_pkg::ADDR_SOFT_STEP, 8'h02);
        reg_wr(dvc_pkg::ADDR_LEFT_GAIN, 8'h80);
        settle(4);
        `CHK(lmute, 1'b1)
        reg_wr(dvc_pkg::ADDR_LEFT_GAIN, 8'h31);
        reg_wr(dvc_pkg::ADDR_RIGHT_GAIN, 8'h81);
        settle(4);
        `CHK(lgain, 10'h0C0)
        `CHK(rgain, 10'h204)
        reg_wr(dvc_pkg::ADDR_PIN_READ, 8'h55);
        check_reg(dvc_pkg::ADDR_PIN_READ, 8'h00);
        reg_wr(dvc_pkg::ADDR_MUTE_MAST, 8'hFC);
        check_reg(dvc_pkg::ADDR_MUTE_MAST, 8'h0C);
        `CHK({lmute, rmute}, 2'b11)
        reg_wr(dvc_pkg::ADDR_MUTE_MAST, 8'h01);
        settle(4);
        `CHK(lgain, 10'h204)
        reg_wr(dvc_pkg::ADDR_MUTE_MAST, 8'h02);
        settle(4);
        `CHK(rgain, 10'h0C0)
        reg_wr(dvc_pkg::ADDR_MUTE_MAST, 8'h00);
    endtask
    task automatic s_pin;
        reg_wr(dvc_pkg::ADDR_SOFT_STEP, 8'h03);
        check_reg(dvc_pkg::ADDR_SOFT_STEP, 8'h03);
        level = 7'h14;
        ticks(70);
        check_reg(dvc_pkg::ADDR_LEFT_GAIN, 8'h31);
        reg_wr(dvc_pkg::ADDR_PIN_CTRL, 8'hC0);
        ticks(10);
        check_reg(dvc_pkg::ADDR_PIN_READ, 8'h14);
        check_reg(dvc_pkg::ADDR_LEFT_GAIN, 8'h10);
        check_reg(dvc_pkg::ADDR_RIGHT_GAIN, 8'h10);
        `CHK(lgain, 10'h040)
        `CHK(trial, 7'h15)
        level = 7'h64;
        ticks(64);
        check_reg(dvc_pkg::ADDR_LEFT_GAIN, 8'hB6);
        level = 7'h7F;
        ticks(64);
        check_reg(dvc_pkg::ADDR_LEFT_GAIN, 8'h80);
        `CHK(lmute, 1'b1)
        reg_wr(dvc_pkg::ADDR_PIN_CTRL, 8'h00);
        level = 7'h00;
        reg_wr(dvc_pkg::ADDR_PIN_CTRL, 8'h80);
        settle(1300);
        check_reg(dvc_pkg::ADDR_LEFT_GAIN, 8'h24);
    endtask
    initial begin
        settle(4);
        rst_n = 1'b1;
        s_reset();
        s_ramp();
        s_half();
        s_off();
        s_pin();
        tally_and_finish();
    end
endmodule // tb_dvc_top
`default_nettype wire
